/* File: logic/dmt_edge_sync.sv */
/*
 * two-stage synchroniser with edge detect for the event pin.
 * assumes pin asynchronous to clk; polarity input is static while counting.
 */
`timescale 1ns/100ps
`default_nettype none
module dmt_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  // pin
  input  wire logic pinIn,
  input  wire logic risingSel,
  // result
  output logic      edgeHit
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic       hit;
    logic [1:0] fill;
  } dmt_sync_s;

  dmt_sync_s st_r;
  dmt_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // only s2/s3 are inspected; s1 feeds s2 alone
    // no edge until the chain holds real pin samples: an idle-high pin
    // would otherwise look like a rising edge right after reset
    st_nxt.fill = (st_r.fill == 2'h3) ? st_r.fill : st_r.fill + 2'h1;
    st_nxt.hit = (st_r.fill == 2'h3) &&
                 (risingSel ? (st_r.s2 & ~st_r.s3) : (~st_r.s2 & st_r.s3));
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign edgeHit = st_r.hit;
endmodule
`default_nettype wire

/* File: logic/dmt_pkg.sv */
/*
 * package for the dual mode compare timer: register offsets, field positions,
 * reset values and prescaler taps.
 * assumes an 8-bit peripheral bus with byte addresses in the 0xFFxx page.
 */
//
// Contract
// - sixteen-bit up-counter from two cascaded byte halves, both CPU readable and writable
// - reset clears both counter halves to zero
// - reset sets both compare halves to all ones
// - mode bit zero cascades halves as sixteen bits; one gives two byte timers
// - in byte mode high half clock from its select: /32,/16,/4,/2
// - in sixteen-bit mode the low select clocks the whole counter
// - low select top bit zero counts event pin edges, else /32,/16,/4,/2
// - sixteen-bit wrap from all ones to zero sets high overflow flag
// - overflow with high overflow enable pulses high interrupt request
// - byte mode wrap of a half sets its overflow flag, request if enabled
// - compare match clears counter when clear-on-match is set, per mode
// - sixteen-bit equality sets high compare flag and request, ungated
// - byte mode equality of a half sets its compare flag and request
// - high output toggles on high or full match; low on low match
// - writing high level bit drives high output to that level at once
// - writing low level bit drives low output to that level at once
// - low level bit zero means low output; low after reset
// - control register is eight bits, write-only, reset to zero
// - sixteen-bit mode writes and counter reads pass through a byte holding register; compare reads do not
// - upper byte written first is held, lower write loads both together
// - flags set by hardware only; cleared by writing zero after reading one
package dmt_pkg;
  localparam logic [15:0] DMT_ADDR_CTRL   = 16'hFFB6;
  localparam logic [15:0] DMT_ADDR_STAT   = 16'hFFB7;
  localparam logic [15:0] DMT_ADDR_CNT_H  = 16'hFFB8;
  localparam logic [15:0] DMT_ADDR_CNT_L  = 16'hFFB9;
  localparam logic [15:0] DMT_ADDR_CMP_H  = 16'hFFBA;
  localparam logic [15:0] DMT_ADDR_CMP_L  = 16'hFFBB;

  localparam logic [7:0]  DMT_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  DMT_STAT_RESET  = 8'h00;
  localparam logic [7:0]  DMT_CNT_RESET   = 8'h00;
  localparam logic [7:0]  DMT_CMP_RESET   = 8'hFF;

  // control register fields
  localparam int DMT_LVL_H   = 7;
  localparam int DMT_MODE    = 6;
  localparam int DMT_CKS_H   = 4;
  localparam int DMT_LVL_L   = 3;
  localparam int DMT_CKS_L   = 0;
  // status register fields
  localparam int DMT_OVF_H   = 7;
  localparam int DMT_CMF_H   = 6;
  localparam int DMT_OVIE_H  = 5;
  localparam int DMT_CCLR_H  = 4;
  localparam int DMT_OVF_L   = 3;
  localparam int DMT_CMF_L   = 2;
  localparam int DMT_OVIE_L  = 1;
  localparam int DMT_CCLR_L  = 0;

  // prescaler taps: divide by 2^(n+1) comes from bit n of a free counter
  localparam int DMT_PRE_W   = 5;
  localparam int DMT_TAP_32  = 4;
  localparam int DMT_TAP_16  = 3;
  localparam int DMT_TAP_4   = 1;
  localparam int DMT_TAP_2   = 0;
endpackage

/* File: logic/dmt_timer.sv */
/*
 * dual mode compare timer: two byte counters, cascaded or independent,
 * compare, overflow, toggle outputs and byte-wide register port.
 * assumes a single-cycle 8-bit bus: wrEn/rdEn are one-cycle strobes with addr.
 * read data is registered and valid the cycle after rdEn.
 */
`timescale 1ns/100ps
`default_nettype none
module dmt_timer
  import dmt_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // register bus
  input  wire logic [15:0] addr,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic [7:0]  wrData,
  output logic      [7:0]  rdData,
  // pins
  input  wire logic        eventIn,
  input  wire logic        eventRising,
  output logic             toggleOutHigh,
  output logic             toggleOutLow,
  // interrupt request set strobes
  output logic             irqSetHigh,
  output logic             irqSetLow
);
  typedef struct packed {
    logic [7:0]           ctrl;
    logic [7:0]           stat;
    logic [7:0]           cntH;
    logic [7:0]           cntL;
    logic [7:0]           cmpH;
    logic [7:0]           cmpL;
    logic [7:0]           hold;
    logic [DMT_PRE_W-1:0] pre;
    logic [5:0]           seenOne;
    logic                 outH;
    logic                 outL;
    logic                 irqH;
    logic                 irqL;
    logic [7:0]           rd;
  } dmt_state_s;

  dmt_state_s st_r;
  dmt_state_s st_nxt;
  logic       evHit;

  dmt_edge_sync u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .pinIn     (eventIn),
    .risingSel (eventRising),
    .edgeHit   (evHit)
  );

  // ********************************************************
  // clock select decode, shared by both halves
  // ********************************************************
  // rising edge of the chosen prescaler tap gives one count tick
  function automatic logic tapTick(input logic [2:0] sel,
                                   input logic [DMT_PRE_W-1:0] cur,
                                   input logic [DMT_PRE_W-1:0] nxt);
    int tap;
    case (sel[1:0])
      2'h0:    tap = DMT_TAP_32;
      2'h1:    tap = DMT_TAP_16;
      2'h2:    tap = DMT_TAP_4;
      default: tap = DMT_TAP_2;
    endcase
    return ~cur[tap] & nxt[tap];
  endfunction

  // byte counter step and its wrap point, shared by both halves
  function automatic logic [7:0] byteStep(input logic [7:0] cur);
    return cur + 8'h01;
  endfunction

  function automatic logic atTop(input logic [7:0] cur);
    return cur == 8'hFF;
  endfunction

  // hardware set wins over a same-cycle software clear
  function automatic logic flagNext(input logic cur,
                                    input logic setEv,
                                    input logic clrEv);
    logic res;
    res = cur;
    if (clrEv) begin
      res = 1'b0;
    end
    if (setEv) begin
      res = 1'b1;
    end
    return res;
  endfunction

  // ********************************************************
  // tick, overflow and compare
  // ********************************************************

  logic                 mode8;
  logic [DMT_PRE_W-1:0] preNxt;
  logic                 tickL;
  logic                 tickH;
  logic                 ovf_flag_low;
  logic                 ovf_flag_high;
  logic                 matchL;
  logic                 matchH;
  logic                 match16;
  logic [7:0]           incL;
  logic [7:0]           incH;

  always_comb begin
    mode8  = st_r.ctrl[DMT_MODE];
    preNxt = st_r.pre + DMT_PRE_W'(1);
    tickL  = st_r.ctrl[DMT_CKS_L+2] ? tapTick(st_r.ctrl[DMT_CKS_L +: 3], st_r.pre, preNxt)
                                    : evHit;
    incL   = byteStep(st_r.cntL);
    ovf_flag_low   = tickL && atTop(st_r.cntL);
    // high half counts low overflows when cascaded
    tickH  = mode8 ? tapTick(st_r.ctrl[DMT_CKS_H +: 3], st_r.pre, preNxt) : ovf_flag_low;
    incH   = byteStep(st_r.cntH);
    ovf_flag_high   = tickH && atTop(st_r.cntH);
    match16 = {st_r.cntH, st_r.cntL} == {st_r.cmpH, st_r.cmpL};
    matchH  = mode8 ? (st_r.cntH == st_r.cmpH) : match16;
    matchL  = mode8 && (st_r.cntL == st_r.cmpL);
  end

  // ********************************************************
  // next state
  // ********************************************************
  logic wrCtrl;
  logic wrStat;
  logic matchHRise;
  logic matchLRise;
  logic wasMatchH;
  logic wasMatchL;
  logic rdStat;
  logic clrOvfH;
  logic clrCmfH;
  logic clrOvfL;
  logic clrCmfL;

  // a zero write clears a flag only if the last status read showed it set;
  // a flag set after that read stays until it has been seen
  always_comb begin
    wrCtrl  = wrEn && (addr == DMT_ADDR_CTRL);
    wrStat  = wrEn && (addr == DMT_ADDR_STAT);
    rdStat  = rdEn && (addr == DMT_ADDR_STAT);
    clrOvfH = wrStat && !wrData[DMT_OVF_H] && st_r.seenOne[2];
    clrCmfH = wrStat && !wrData[DMT_CMF_H] && st_r.seenOne[3];
    clrOvfL = wrStat && !wrData[DMT_OVF_L] && st_r.seenOne[4];
    clrCmfL = wrStat && !wrData[DMT_CMF_L] && st_r.seenOne[5];
  end

  // ********************************************************
  // state update
  // ********************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.pre  = preNxt;
    st_nxt.irqH = 1'b0;
    st_nxt.irqL = 1'b0;
    // events fire on the cycle equality starts, not every cycle it holds
    wasMatchH  = st_r.seenOne[0];
    wasMatchL  = st_r.seenOne[1];
    matchHRise = matchH && !wasMatchH;
    matchLRise = matchL && !wasMatchL;
    st_nxt.seenOne[0] = matchH;
    st_nxt.seenOne[1] = matchL;

    // counting; clear-on-match acts on the following tick
    if (tickL) begin
      if (st_r.stat[DMT_CCLR_L] && matchL) begin
        st_nxt.cntL = 8'h00;
      end else if (!mode8 && st_r.stat[DMT_CCLR_H] && match16) begin
        st_nxt.cntL = 8'h00;
      end else begin
        st_nxt.cntL = incL;
      end
    end
    if (!mode8 && st_r.stat[DMT_CCLR_H] && match16 && tickL) begin
      st_nxt.cntH = 8'h00;
    end else if (mode8 && st_r.stat[DMT_CCLR_H] && matchH && tickH) begin
      st_nxt.cntH = 8'h00;
    end else if (tickH) begin
      st_nxt.cntH = incH;
    end

    // control bits follow the write; the flags take only qualified zeros
    if (wrStat) begin
      st_nxt.stat[DMT_OVIE_H] = wrData[DMT_OVIE_H];
      st_nxt.stat[DMT_CCLR_H] = wrData[DMT_CCLR_H];
      st_nxt.stat[DMT_OVIE_L] = wrData[DMT_OVIE_L];
      st_nxt.stat[DMT_CCLR_L] = wrData[DMT_CCLR_L];
      st_nxt.seenOne[5:2] = 4'h0;
    end
    if (rdStat) begin
      st_nxt.seenOne[2] = st_r.stat[DMT_OVF_H];
      st_nxt.seenOne[3] = st_r.stat[DMT_CMF_H];
      st_nxt.seenOne[4] = st_r.stat[DMT_OVF_L];
      st_nxt.seenOne[5] = st_r.stat[DMT_CMF_L];
    end
    st_nxt.stat[DMT_OVF_H] = flagNext(st_r.stat[DMT_OVF_H], ovf_flag_high, clrOvfH);
    st_nxt.stat[DMT_CMF_H] = flagNext(st_r.stat[DMT_CMF_H], matchHRise, clrCmfH);
    st_nxt.stat[DMT_OVF_L] = flagNext(st_r.stat[DMT_OVF_L], mode8 && ovf_flag_low, clrOvfL);
    st_nxt.stat[DMT_CMF_L] = flagNext(st_r.stat[DMT_CMF_L], matchLRise, clrCmfL);

    // hardware sets win over a same-cycle clear
    if (ovf_flag_high) begin
      st_nxt.stat[DMT_OVF_H] = 1'b1;
      st_nxt.irqH = st_r.stat[DMT_OVIE_H];
    end
    if (mode8 && ovf_flag_low) begin
      st_nxt.stat[DMT_OVF_L] = 1'b1;
      st_nxt.irqL = st_r.stat[DMT_OVIE_L];
    end
    if (matchHRise) begin
      st_nxt.stat[DMT_CMF_H] = 1'b1;
      st_nxt.irqH = 1'b1;
      st_nxt.outH = ~st_r.outH;
    end
    if (matchLRise) begin
      st_nxt.stat[DMT_CMF_L] = 1'b1;
      st_nxt.irqL = 1'b1;
      st_nxt.outL = ~st_r.outL;
    end

    // control register and level presets
    if (wrCtrl) begin
      st_nxt.ctrl = wrData;
      st_nxt.outH = wrData[DMT_LVL_H];
      st_nxt.outL = wrData[DMT_LVL_L];
    end

    // counter and compare writes; cascaded mode goes through the holding byte
    if (wrEn) begin
      case (addr)
        DMT_ADDR_CNT_H: begin
          if (mode8) st_nxt.cntH = wrData;
          else       st_nxt.hold = wrData;
        end
        DMT_ADDR_CNT_L: begin
          st_nxt.cntL = wrData;
          if (!mode8) st_nxt.cntH = st_r.hold;
        end
        DMT_ADDR_CMP_H: begin
          if (mode8) st_nxt.cmpH = wrData;
          else       st_nxt.hold = wrData;
        end
        DMT_ADDR_CMP_L: begin
          st_nxt.cmpL = wrData;
          if (!mode8) st_nxt.cmpH = st_r.hold;
        end
        default: begin
        end
      endcase
    end

    // reads; upper counter read in cascaded mode latches the lower byte
    if (rdEn) begin
      case (addr)
        DMT_ADDR_STAT:  st_nxt.rd = st_r.stat;
        DMT_ADDR_CNT_H: begin
          st_nxt.rd = st_r.cntH;
          if (!mode8) st_nxt.hold = st_r.cntL;
        end
        DMT_ADDR_CNT_L: st_nxt.rd = mode8 ? st_r.cntL : st_r.hold;
        DMT_ADDR_CMP_H: st_nxt.rd = st_r.cmpH;
        DMT_ADDR_CMP_L: st_nxt.rd = st_r.cmpL;
        default:        st_nxt.rd = 8'hFF;
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.ctrl    <= DMT_CTRL_RESET;
      st_r.stat    <= DMT_STAT_RESET;
      st_r.cntH    <= DMT_CNT_RESET;
      st_r.cntL    <= DMT_CNT_RESET;
      st_r.cmpH    <= DMT_CMP_RESET;
      st_r.cmpL    <= DMT_CMP_RESET;
      st_r.rd      <= 8'hFF;
      st_r.seenOne <= 6'h00;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************
  // outputs, each straight from a state flop
  // ********************************************************
  assign rdData        = st_r.rd;
  assign toggleOutHigh = st_r.outH;
  assign toggleOutLow  = st_r.outL;
  assign irqSetHigh    = st_r.irqH;
  assign irqSetLow     = st_r.irqL;
endmodule
`default_nettype wire

/* File: verification/dmt_timer_assertions.sv */
/* checker for the dual mode compare timer port relations.
   assumes a bind onto dmt_timer and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module dmt_timer_checker
  import dmt_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clkEn,
  // register bus
  input wire logic [15:0] addr,
  input wire logic        wrEn,
  input wire logic        rdEn,
  input wire logic [7:0]  wrData,
  input wire logic [7:0]  rdData,
  // pins and strobes
  input wire logic        toggleOutHigh,
  input wire logic        toggleOutLow,
  input wire logic        irqSetHigh,
  input wire logic        irqSetLow
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ****
  // assertions
  // ****
  chk_ctrl_read_ff: assert property (rdEn && clkEn && addr == DMT_ADDR_CTRL |=> rdData == 8'hFF)
    else $error("control read not all ones");
  chk_level_high: assert property (wrEn && clkEn && addr == DMT_ADDR_CTRL |=> toggleOutHigh == $past(wrData[7]))
    else $error("high output ignores level write");
  chk_level_low: assert property (wrEn && clkEn && addr == DMT_ADDR_CTRL |=> toggleOutLow == $past(wrData[3]))
    else $error("low output ignores level write");
  chk_out_reset:
    assert property ($rose(reset_n) |-> rdData == 8'hFF && !toggleOutHigh && !toggleOutLow && !irqSetHigh && !irqSetLow)
    else $error("outputs wrong after reset");
  chk_irq_high_pulse: assert property (irqSetHigh && clkEn |=> !irqSetHigh)
    else $error("high strobe longer than a cycle");
  chk_irq_low_pulse: assert property (irqSetLow && clkEn |=> !irqSetLow)
    else $error("low strobe longer than a cycle");
  chk_toggle_high_cause:
    assert property ($changed(toggleOutHigh) |-> $past(wrEn && addr == DMT_ADDR_CTRL) || irqSetHigh)
    else $error("high output moved without cause");
  chk_toggle_low_cause:
    assert property ($changed(toggleOutLow) |-> $past(wrEn && addr == DMT_ADDR_CTRL) || irqSetLow)
    else $error("low output moved without cause");
  chk_read_stands: assert property ($changed(rdData) |-> $past(rdEn))
    else $error("read data moved without a read");
  cover property (irqSetHigh);
  cover property (irqSetLow);
  cover property ($rose(toggleOutLow));
endmodule

bind dmt_timer dmt_timer_checker i_chk (
  .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
  .wrData(wrData), .rdData(rdData), .toggleOutHigh(toggleOutHigh), .toggleOutLow(toggleOutLow),
  .irqSetHigh(irqSetHigh), .irqSetLow(irqSetLow)
);
`default_nettype wire

/* File: verification/tb.sv */
/* self-checking bench for the dual mode compare timer.
   assumes dmt_pkg, the design and its checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dmt_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        clkEn;
  logic [15:0] addr;
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  wrData;
  logic [7:0]  rdData;
  logic        eventIn;
  logic        eventRising;
  logic        toggleOutHigh;
  logic        toggleOutLow;
  logic        irqSetHigh;
  logic        irqSetLow;
  logic [7:0]  v;
  int          n_errors;
  int          checks;
  int          nIrqH;
  int          nIrqL;
  int          i;

  dmt_timer i_dut (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .addr(addr), .wrEn(wrEn), .rdEn(rdEn),
    .wrData(wrData), .rdData(rdData), .eventIn(eventIn), .eventRising(eventRising),
    .toggleOutHigh(toggleOutHigh), .toggleOutLow(toggleOutLow), .irqSetHigh(irqSetHigh), .irqSetLow(irqSetLow)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // strobes counted on the falling edge, clear of the launching edge
  always @(negedge clk) begin
    nIrqH += int'(irqSetHigh === 1'b1);
    nIrqL += int'(irqSetLow === 1'b1);
  end
  // ****
  // bus and check tasks
  // ****
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // prescaler phase is unknown, so rates get one step of slack
  task automatic near(string what, logic [7:0] seen, int exp);
    check(what, {7'h00, seen + 1 >= exp && seen <= exp + 1}, 8'h01);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic rdc(string what, logic [15:0] a, logic [7:0] exp);
    rd(a, v);
    check(what, v, exp);
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_reset;
    rdc("count_high", DMT_ADDR_CNT_H, 8'h00);
    rdc("count_low", DMT_ADDR_CNT_L, 8'h00);
    rdc("compare_high", DMT_ADDR_CMP_H, 8'hFF);
    rdc("compare_low", DMT_ADDR_CMP_L, 8'hFF);
    rdc("status", DMT_ADDR_STAT, 8'h00);
    rdc("control", DMT_ADDR_CTRL, 8'hFF);
    wr(16'hFFBC, 8'h5A);
    rdc("unmapped", 16'hFFBC, 8'hFF);
    $display("test reset done");
  endtask
  task automatic test_pairing;
    wr(DMT_ADDR_CNT_H, 8'hAA);
    wr(DMT_ADDR_CNT_L, 8'h55);
    rdc("pair_high", DMT_ADDR_CNT_H, 8'hAA);
    rdc("pair_low", DMT_ADDR_CNT_L, 8'h55);
    wr(DMT_ADDR_CMP_H, 8'h12);
    rdc("cmp_held", DMT_ADDR_CMP_H, 8'hFF);
    wr(DMT_ADDR_CMP_L, 8'h34);
    rdc("cmp_high", DMT_ADDR_CMP_H, 8'h12);
    rdc("cmp_low", DMT_ADDR_CMP_L, 8'h34);
    wr(DMT_ADDR_CMP_H, 8'hFF);
    wr(DMT_ADDR_CMP_L, 8'hFF);
    $display("test pairing done");
  endtask
  task automatic test_events;
    int n;
    wr(DMT_ADDR_STAT, 8'h20);
    wr(DMT_ADDR_CNT_H, 8'hFF);
    wr(DMT_ADDR_CNT_L, 8'hFE);
    n = nIrqH;
    repeat (2) begin
      @(posedge clk);
      eventIn <= 1'b1;
      repeat (4) @(posedge clk);
      eventIn <= 1'b0;
      repeat (4) @(posedge clk);
    end
    check("irq_high_count", 8'(nIrqH - n), 8'h02);
    check("out_high_match", {7'h00, toggleOutHigh}, 8'h01);
    rdc("flags_high", DMT_ADDR_STAT, 8'hE0);
    rdc("wrap_high", DMT_ADDR_CNT_H, 8'h00);
    rdc("wrap_low", DMT_ADDR_CNT_L, 8'h00);
    wr(DMT_ADDR_STAT, 8'h20);
    wr(DMT_ADDR_STAT, 8'hE0);
    rdc("flags_cleared", DMT_ADDR_STAT, 8'h20);
    $display("test events done");
  endtask
  task automatic test_rates;
    int dv[4] = '{32, 16, 4, 2};
    logic [2:0] cks;
    wr(DMT_ADDR_CTRL, 8'hFF);
    @(negedge clk);
    check("levels_set", {6'h00, toggleOutHigh, toggleOutLow}, 8'h03);
    for (int k = 0; k < 4; k++) begin
      cks = 3'(4 + k);
      wr(DMT_ADDR_CTRL, {2'b01, cks[1:0], 1'b0, cks});
      wr(DMT_ADDR_CNT_L, 8'h00);
      wr(DMT_ADDR_CNT_H, 8'h00);
      repeat (64) @(posedge clk);
      rd(DMT_ADDR_CNT_L, v);
      near("rate_low", v, 68 / dv[k]);
      rd(DMT_ADDR_CNT_H, v);
      near("rate_high", v, 68 / dv[k]);
    end
    check("levels_cleared", {6'h00, toggleOutHigh, toggleOutLow}, 8'h00);
    $display("test rates done");
  endtask
  task automatic test_low;
    int n;
    wr(DMT_ADDR_CTRL, 8'h47);
    wr(DMT_ADDR_CMP_L, 8'h05);
    wr(DMT_ADDR_STAT, 8'h03);
    wr(DMT_ADDR_CNT_L, 8'h00);
    for (i = 0; i < 100 && irqSetLow !== 1'b1; i++) @(negedge clk);
    check("match_low", {7'h00, i < 100}, 8'h01);
    check("out_low_match", {7'h00, toggleOutLow}, 8'h01);
    rdc("status_low", DMT_ADDR_STAT, 8'h07);
    rd(DMT_ADDR_CNT_L, v);
    check("clear_low", {7'h00, v <= 8'h05}, 8'h01);
    wr(DMT_ADDR_CMP_L, 8'h80);
    wr(DMT_ADDR_STAT, 8'h02);
    n = nIrqL;
    wr(DMT_ADDR_CNT_L, 8'hF0);
    repeat (40) @(posedge clk);
    check("irq_low_count", 8'(nIrqL - n), 8'h01);
    rd(DMT_ADDR_STAT, v);
    check("ovf_low", {7'h00, v[DMT_OVF_L]}, 8'h01);
    check("cmf_low_cleared", {7'h00, v[DMT_CMF_L]}, 8'h00);
    $display("test low half done");
  endtask
  task automatic test_full_clear;
    wr(DMT_ADDR_CTRL, 8'h07);
    wr(DMT_ADDR_CMP_H, 8'h00);
    wr(DMT_ADDR_CMP_L, 8'h04);
    wr(DMT_ADDR_STAT, 8'h10);
    wr(DMT_ADDR_CNT_H, 8'h00);
    wr(DMT_ADDR_CNT_L, 8'h00);
    for (i = 0; i < 100 && irqSetHigh !== 1'b1; i++) @(negedge clk);
    check("match_full", {7'h00, i < 100}, 8'h01);
    check("out_high_full", {7'h00, toggleOutHigh}, 8'h01);
    rdc("clear_full_high", DMT_ADDR_CNT_H, 8'h00);
    rd(DMT_ADDR_CNT_L, v);
    check("clear_full_low", {7'h00, v <= 8'h04}, 8'h01);
    $display("test full clear done");
  endtask
  task automatic test_freeze;
    logic [7:0] v0;
    // byte mode, low half at /2: only three enabled edges lie between the reads
    wr(DMT_ADDR_CTRL, 8'h77);
    rd(DMT_ADDR_CNT_L, v0);
    @(posedge clk);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk);
    clkEn <= 1'b1;
    rd(DMT_ADDR_CNT_L, v);
    near("freeze_low", 8'(v - v0), 2);
    // falling polarity: the rising pin edge must not count
    wr(DMT_ADDR_CTRL, 8'h40);
    eventRising <= 1'b0;
    rd(DMT_ADDR_CNT_L, v0);
    @(posedge clk);
    eventIn <= 1'b1;
    repeat (4) @(posedge clk);
    eventIn <= 1'b0;
    repeat (4) @(posedge clk);
    rd(DMT_ADDR_CNT_L, v);
    check("fall_count", 8'(v - v0), 8'h01);
    $display("test freeze done");
  endtask
  // ****
  // run control
  // ****
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    addr = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    wrData = 8'h00;
    eventIn = 1'b0;
    eventRising = 1'b1;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    test_reset;
    test_pairing;
    test_events;
    test_rates;
    test_low;
    test_full_clear;
    test_freeze;
    stop_test;
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
